/* verilog/aosc_pkg.sv */
/*
 * Shared constants and types for the two-channel analog output setpoint
 * controller. Assumes a single 200 MHz clock and setpoints in signed units.
 */
`default_nettype none

package aosc_pkg;
  localparam int NCH = 2;
  localparam int CH_W = 1;
  localparam int SP_W = 16;
  localparam int VAL_W = 17;
  localparam int CODE_W = 16;
  localparam int GAIN_W = 18;
  localparam int GAIN_SH = 12;

  typedef enum logic [1:0] {RNG_V10, RNG_I020, RNG_I420} aosc_range_t;
  typedef enum logic [1:0] {LIM_UPPER, LIM_LOWER, LIM_BOTH} aosc_lim_t;
  typedef enum logic [1:0] {MODE_RUN, MODE_FALLBACK, MODE_HOLD,
    MODE_ZERO} aosc_mode_t;
  typedef enum logic [1:0] {B_NOM_HI, B_NOM_LO, B_OUT_HI, B_OUT_LO} aosc_bnd_t;

  // Area bounds in setpoint units
  localparam logic signed [VAL_W-1:0] V_NOM_HI = 17'sh02af8;
  localparam logic signed [VAL_W-1:0] V_NOM_LO = -17'sh02af8;
  localparam logic signed [VAL_W-1:0] V_OUT_HI = 17'sh02bf2;
  localparam logic signed [VAL_W-1:0] V_OUT_LO = -17'sh02bf2;
  localparam logic signed [VAL_W-1:0] I0_NOM_HI = 17'sh02af8;
  localparam logic signed [VAL_W-1:0] I0_NOM_LO = -17'sh003e8;
  localparam logic signed [VAL_W-1:0] I0_OUT_HI = 17'sh02ee0;
  localparam logic signed [VAL_W-1:0] I0_OUT_LO = -17'sh007d0;
  localparam logic signed [VAL_W-1:0] I4_NOM_HI = 17'sh02a30;
  localparam logic signed [VAL_W-1:0] I4_NOM_LO = -17'sh00320;
  localparam logic signed [VAL_W-1:0] I4_OUT_HI = 17'sh02d50;
  localparam logic signed [VAL_W-1:0] I4_OUT_LO = -17'sh00640;

  // Nominal calibration, gain in Q12, offset in codes
  localparam logic signed [GAIN_W-1:0] V_GAIN = 18'sh02e9a;
  localparam logic signed [GAIN_W-1:0] I0_GAIN = 18'sh02bb0;
  localparam logic signed [GAIN_W-1:0] I4_GAIN = 18'sh022f3;
  localparam logic signed [GAIN_W-1:0] I4_OFS = 18'sh01555;
  localparam logic signed [CODE_W-1:0] CODE_HI = 16'sh7fff;
  localparam logic signed [CODE_W-1:0] CODE_V_LO = -16'sh7fff - 16'sh0001;

  localparam logic signed [SP_W-1:0] ALIGN_MAX = 16'sh05dc;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int REFRESH_US = 1000;
  localparam int WDOG_US = 2000;
  localparam int COMM_US = 10000;
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
  localparam int WDOG_CYC = WDOG_US * CLK_MHZ;
  localparam int COMM_CYC = COMM_US * CLK_MHZ;
endpackage

`default_nettype wire

/* verilog/aosc_chan_if.sv */
/*
 * Carrier between the controller and one channel converter.
 * Assumes the controller drives it and the converter answers on load.
 */
`default_nettype none

interface aosc_chan_if;
  import aosc_pkg::*;
  aosc_range_t range;
  logic lim_en;
  aosc_lim_t lim_mode;
  logic signed [VAL_W-1:0] value;
  logic signed [CODE_W-1:0] gain_trim;
  logic signed [CODE_W-1:0] ofs_trim;
  logic load;
  logic zero;
  logic hold;
  logic [CODE_W-1:0] code;
  logic ovf;
  logic unf;
  modport ctrl (output range, lim_en, lim_mode, value, gain_trim, ofs_trim,
    load, zero, hold, input code, ovf, unf);
  modport conv (input range, lim_en, lim_mode, value, gain_trim, ofs_trim,
    load, zero, hold, output code, ovf, unf);
endinterface

`default_nettype wire

/* verilog/aosc_chan.sv */
/*
 * One channel: classification, saturation, calibration and code register.
 * Assumes load pulses once per refresh; zero and hold are decided upstream.
 */
`default_nettype none

module aosc_chan (
  input wire logic clk_sys,
  input wire logic rst,
  aosc_chan_if.conv ch
);
  import aosc_pkg::*;
  localparam int PW = VAL_W + GAIN_W;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  function automatic logic signed [VAL_W-1:0] bound(input aosc_range_t r,
      input aosc_bnd_t b);
    logic signed [VAL_W-1:0] v;
    v = '0;
    case (r)
      RNG_I020: v = (b == B_NOM_HI) ? I0_NOM_HI : (b == B_NOM_LO) ? I0_NOM_LO :
        (b == B_OUT_HI) ? I0_OUT_HI : I0_OUT_LO;
      RNG_I420: v = (b == B_NOM_HI) ? I4_NOM_HI : (b == B_NOM_LO) ? I4_NOM_LO :
        (b == B_OUT_HI) ? I4_OUT_HI : I4_OUT_LO;
      default: v = (b == B_NOM_HI) ? V_NOM_HI : (b == B_NOM_LO) ? V_NOM_LO :
        (b == B_OUT_HI) ? V_OUT_HI : V_OUT_LO;
    endcase
    return v;
  endfunction

  logic is_v;
  logic signed [VAL_W-1:0] nom_hi, nom_lo, out_hi, out_lo, sat;
  logic above, below, ovf_d, unf_d;
  logic signed [GAIN_W-1:0] gain, ofs;
  logic signed [PW-1:0] prod, cv, lo, cv_c;
  logic [CODE_W-1:0] code_d;

  assign is_v = ch.range == RNG_V10;
  assign nom_hi = bound(ch.range, B_NOM_HI);
  assign nom_lo = bound(ch.range, B_NOM_LO);
  assign out_hi = bound(ch.range, B_OUT_HI);
  assign out_lo = bound(ch.range, B_OUT_LO);
  assign above = ch.value > nom_hi;
  assign below = ch.value < nom_lo;
  // An undefined limit mode flags both ways
  assign ovf_d = ch.lim_en && above && ch.lim_mode != LIM_LOWER;
  assign unf_d = ch.lim_en && below && ch.lim_mode != LIM_UPPER;
  assign sat = (ch.value > out_hi) ? out_hi :
    (ch.value < out_lo) ? out_lo : ch.value;

  // Nominal line plus factory trim
  assign gain = ((ch.range == RNG_I020) ? I0_GAIN :
    (ch.range == RNG_I420) ? I4_GAIN : V_GAIN) + GAIN_W'(ch.gain_trim);
  assign ofs = ((ch.range == RNG_I420) ? I4_OFS : '0) +
    GAIN_W'(ch.ofs_trim);
  assign prod = PW'(sat) * PW'(gain);
  assign cv = (prod >>> GAIN_SH) + PW'(ofs);
  // A current loop cannot sink, so its code floors at zero
  assign lo = is_v ? PW'(CODE_V_LO) : '0;
  assign cv_c = (cv > PW'(CODE_HI)) ? PW'(CODE_HI) : (cv < lo) ? lo : cv;
  assign code_d = cv_c[CODE_W-1:0];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ch.code <= '0;
      ch.ovf <= 1'b0;
      ch.unf <= 1'b0;
    end else if (ch.load) begin
      ch.code <= ch.zero ? '0 : ch.hold ? ch.code : code_d;
      ch.ovf <= !ch.zero && ovf_d;
      ch.unf <= !ch.zero && unf_d;
    end
  end

  cur_code_a: assert property (ch.range != RNG_V10 |-> !ch.code[CODE_W-1])
    else $error("current code uses sign bit");
  ovf_flag_a: assert property ((ch.load && !ch.zero && ch.lim_en &&
      ch.lim_mode == LIM_UPPER && ch.value > nom_hi) |=> ch.ovf ##0 !ch.unf)
    else $error("overflow flag missing");
  sat_code_a: assert property ((ch.load && !ch.zero && !ch.hold &&
      ch.range == RNG_V10 && ch.value > V_OUT_HI) |=>
      ch.code == $past(code_d) ##0 $past(sat) == V_OUT_HI)
    else $error("value not saturated");
  ovf_seen_c: cover property (ch.load ##1 ch.ovf);
endmodule

`default_nettype wire

/* verilog/aosc_top.sv */
/*
 * Two-channel analog output setpoint controller, top level.
 * Assumes the processor-side strobes are on clk_sys and the analog sense
 * and supply pins are asynchronous.
 */
`default_nettype none

module aosc_top #(
  parameter int REFRESH_CYCLES = aosc_pkg::REFRESH_CYC,
  parameter int WDOG_CYCLES = aosc_pkg::WDOG_CYC,
  parameter int COMM_CYCLES = aosc_pkg::COMM_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire aosc_pkg::aosc_range_t cfg_range [aosc_pkg::NCH],
  input wire logic [aosc_pkg::NCH-1:0] cfg_lim_en,
  input wire aosc_pkg::aosc_lim_t cfg_lim_mode [aosc_pkg::NCH],
  input wire logic [aosc_pkg::NCH-1:0] cfg_maintain,
  input wire logic [aosc_pkg::NCH-1:0] cfg_wire_chk,
  input wire logic sp_wr,
  input wire logic [aosc_pkg::CH_W-1:0] sp_ch,
  input wire logic signed [aosc_pkg::SP_W-1:0] sp_val,
  input wire logic fb_wr,
  input wire logic [aosc_pkg::CH_W-1:0] fb_ch,
  input wire logic signed [aosc_pkg::SP_W-1:0] fb_val,
  input wire logic align_wr,
  input wire logic align_clr,
  input wire logic [aosc_pkg::CH_W-1:0] align_ch,
  input wire logic signed [aosc_pkg::SP_W-1:0] align_val,
  input wire logic cal_wr,
  input wire logic [aosc_pkg::CH_W-1:0] cal_ch,
  input wire logic signed [aosc_pkg::CODE_W-1:0] cal_gain,
  input wire logic signed [aosc_pkg::CODE_W-1:0] cal_ofs,
  input wire logic task_run,
  input wire logic prog_ok,
  input wire logic hot_swap,
  input wire logic prog_reload,
  input wire logic int_err_in,
  input wire logic pwr_ok_pin,
  input wire logic [aosc_pkg::NCH-1:0] short_pin,
  input wire logic [aosc_pkg::NCH-1:0] open_pin,
  output logic [aosc_pkg::CODE_W-1:0] dac_code [aosc_pkg::NCH],
  output logic dac_load,
  output logic [aosc_pkg::NCH-1:0] stat_ovf,
  output logic [aosc_pkg::NCH-1:0] stat_unf,
  output logic [aosc_pkg::NCH-1:0] stat_short,
  output logic [aosc_pkg::NCH-1:0] stat_open,
  output logic stat_pwr_err,
  output logic stat_cfg_err,
  output logic stat_int_err,
  output logic stat_comm_err,
  output logic [aosc_pkg::NCH-1:0] aligned,
  output logic signed [aosc_pkg::SP_W-1:0] align_rd [aosc_pkg::NCH]
);
  import aosc_pkg::*;
  localparam int PIN_W = 2 * NCH + 1;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  logic [PIN_W-1:0] s1_q, s2_q, s3_q, pin_q;
  logic pwr_ok;
  logic [NCH-1:0] short_f, open_f;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= {open_pin, short_pin, pwr_ok_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Moves only when the last two stages agree
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end

  assign pwr_ok = pin_q[0];
  assign short_f = pin_q[NCH:1];
  assign open_f = pin_q[2*NCH:NCH+1];

  // ***********************************************************
  // Refresh divider, watchdog, link timeout
  // ***********************************************************
  logic [31:0] div_q, wd_q, cm_q, gap_q;
  logic tick, wd_err_q, comm_lost, seen_q;

  assign tick = div_q == 32'(REFRESH_CYCLES - 1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      wd_q <= '0;
      cm_q <= '0;
      wd_err_q <= 1'b0;
      dac_load <= 1'b0;
    end else begin
      div_q <= tick ? '0 : div_q + 32'h0000_0001;
      // Watchdog checks that the refresh engine keeps running
      wd_q <= tick ? '0 : wd_q + 32'h0000_0001;
      wd_err_q <= wd_err_q | (wd_q >= 32'(WDOG_CYCLES));
      if (sp_wr) begin
        cm_q <= '0;
      end else if (!comm_lost) begin
        cm_q <= cm_q + 32'h0000_0001;
      end
      dac_load <= tick;
    end
  end

  assign comm_lost = cm_q >= 32'(COMM_CYCLES);

  // ***********************************************************
  // Setpoint, fallback, alignment and calibration stores
  // ***********************************************************
  logic signed [SP_W-1:0] sp_q [NCH];
  logic signed [SP_W-1:0] fb_q [NCH];
  logic signed [SP_W-1:0] align_q [NCH];
  logic signed [CODE_W-1:0] gain_q [NCH];
  logic signed [CODE_W-1:0] ofs_q [NCH];
  logic [NCH-1:0] aligned_q;
  logic signed [SP_W-1:0] align_c;

  // Out-of-limit alignment is clipped rather than refused
  assign align_c = (align_val > ALIGN_MAX) ? ALIGN_MAX :
    (align_val < -ALIGN_MAX) ? -ALIGN_MAX : align_val;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        sp_q[i] <= '0;
        fb_q[i] <= '0;
        align_q[i] <= '0;
        gain_q[i] <= '0;
        ofs_q[i] <= '0;
      end
      aligned_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (sp_wr && sp_ch == CH_W'(i)) begin
          sp_q[i] <= sp_val;
        end
        if (fb_wr && fb_ch == CH_W'(i)) begin
          fb_q[i] <= fb_val;
        end
        if (align_wr && align_ch == CH_W'(i)) begin
          align_q[i] <= align_c;
        end
        if (cal_wr && cal_ch == CH_W'(i)) begin
          gain_q[i] <= cal_gain;
          ofs_q[i] <= cal_ofs;
        end
        // A save in the same cycle as a clear leaves the flag set
        aligned_q[i] <= (aligned_q[i] && !(align_clr &&
          align_ch == CH_W'(i))) || (align_wr && align_ch == CH_W'(i));
      end
    end
  end

  // ***********************************************************
  // Output mode selection
  // ***********************************************************
  function automatic aosc_mode_t pick_mode(input logic zero_all,
      input logic fault, input logic stop, input logic maint);
    aosc_mode_t m;
    m = MODE_RUN;
    if (zero_all) begin
      m = MODE_ZERO;
    end else if (fault) begin
      m = MODE_HOLD;
    end else if (stop) begin
      m = maint ? MODE_HOLD : MODE_FALLBACK;
    end
    return m;
  endfunction

  logic cfg_err, int_err, zero_all, stop;
  logic [NCH-1:0] bad_rng, fault, v_short, i_open;
  aosc_mode_t mode [NCH];
  logic signed [VAL_W-1:0] val_sel [NCH];

  assign cfg_err = |bad_rng;
  assign int_err = wd_err_q | int_err_in;
  // Supply loss doubles as the power-up and power-down hold-off
  assign zero_all = !pwr_ok || cfg_err || int_err || hot_swap ||
    prog_reload;
  assign stop = !task_run || !prog_ok || comm_lost;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    aosc_chan_if chi ();

    assign bad_rng[i] = !(cfg_range[i] inside {RNG_V10, RNG_I020, RNG_I420});
    assign v_short[i] = cfg_range[i] == RNG_V10 && short_f[i];
    assign i_open[i] = cfg_range[i] != RNG_V10 && cfg_wire_chk[i] &&
      dac_code[i] != '0 && open_f[i];
    assign fault[i] = v_short[i] || i_open[i];
    assign mode[i] = pick_mode(zero_all, fault[i], stop, cfg_maintain[i]);
    assign val_sel[i] = (mode[i] == MODE_FALLBACK) ? VAL_W'(fb_q[i]) :
      VAL_W'(sp_q[i]) + VAL_W'(align_q[i]);

    assign chi.range = cfg_range[i];
    assign chi.lim_en = cfg_lim_en[i];
    assign chi.lim_mode = cfg_lim_mode[i];
    assign chi.value = val_sel[i];
    assign chi.gain_trim = gain_q[i];
    assign chi.ofs_trim = ofs_q[i];
    assign chi.load = tick;
    assign chi.zero = mode[i] == MODE_ZERO;
    assign chi.hold = mode[i] == MODE_HOLD;
    assign dac_code[i] = chi.code;
    assign stat_ovf[i] = chi.ovf;
    assign stat_unf[i] = chi.unf;

    aosc_chan u_chan (
      .clk_sys(clk_sys),
      .rst(rst),
      .ch(chi)
    );

    hold_out_a: assert property ((tick && !zero_all && v_short[i]) |=>
        $stable(dac_code[i]))
      else $error("shorted channel did not hold");
    fb_sel_a: assert property ((!zero_all && !fault[i] && stop &&
        !cfg_maintain[i]) |-> val_sel[i] == VAL_W'(fb_q[i]))
      else $error("fallback value not selected");
    align_lim_a: assert property (align_q[i] <= ALIGN_MAX &&
        align_q[i] >= -ALIGN_MAX)
      else $error("alignment beyond limit");
    align_flag_a: assert property ((align_wr && align_ch == CH_W'(i)) |=>
        aligned[i] && align_rd[i] == $past(align_c))
      else $error("aligned flag or value missing");
    open_gate_a: assert property ((cfg_range[i] != RNG_V10 &&
        !cfg_wire_chk[i]) |-> !fault[i] ##1 !stat_open[i])
      else $error("open detect without wiring check");
    run_sum_a: assert property ((mode[i] == MODE_RUN) |->
        val_sel[i] == VAL_W'(sp_q[i]) + VAL_W'(align_q[i]))
      else $error("alignment not applied");
  end

  // ***********************************************************
  // Status
  // ***********************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat_short <= '0;
      stat_open <= '0;
      stat_pwr_err <= 1'b0;
      stat_cfg_err <= 1'b0;
      stat_int_err <= 1'b0;
      stat_comm_err <= 1'b0;
    end else begin
      stat_short <= v_short;
      stat_open <= i_open;
      stat_pwr_err <= !pwr_ok;
      stat_cfg_err <= cfg_err;
      stat_int_err <= int_err;
      stat_comm_err <= comm_lost;
    end
  end

  assign aligned = aligned_q;
  for (genvar i = 0; i < NCH; i++) begin : g_rd
    assign align_rd[i] = align_q[i];
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= tick ? '0 : gap_q + 32'h0000_0001;
      seen_q <= seen_q | tick;
    end
  end

  tick_gap_a: assert property ((tick && seen_q) |->
      gap_q == 32'(REFRESH_CYCLES - 1))
    else $error("refresh period wrong");
  cfg_zero_a: assert property ((tick && (cfg_err || int_err)) |=>
      dac_code[0] == '0 && dac_code[1] == '0 && dac_load)
    else $error("error did not zero outputs");
  swap_zero_a: assert property ((tick && (hot_swap || prog_reload)) |=>
      dac_code[0] == '0 && dac_code[1] == '0)
    else $error("swap or reload did not zero outputs");
  pwr_zero_a: assert property ((tick && !pwr_ok) |=>
      dac_code[0] == '0 && dac_code[1] == '0 && stat_pwr_err)
    else $error("supply loss did not zero outputs");
  comm_err_a: assert property ((!sp_wr && comm_lost) |=> stat_comm_err)
    else $error("link loss not reported");

  fallback_c: cover property (tick && mode[0] == MODE_FALLBACK);
  hold_c: cover property (tick && mode[1] == MODE_HOLD);
  zero_c: cover property (tick && zero_all ##1 !zero_all);
  run_c: cover property (tick && mode[0] == MODE_RUN && mode[1] == MODE_RUN);
endmodule

`default_nettype wire

/* tb/aosc_cpu_model.sv */
/*
 * Processor-side model: writes setpoint, fallback and alignment words.
 * Assumes the controller takes a strobe on the rising edge of clk_sys.
 */
`default_nettype none

module aosc_cpu_model (
  input wire logic clk_sys,
  input wire aosc_pkg::aosc_range_t cfg_range [aosc_pkg::NCH],
  output logic sp_wr,
  output logic fb_wr,
  output logic align_wr,
  output logic align_clr,
  output logic [aosc_pkg::CH_W-1:0] wr_ch,
  output logic signed [aosc_pkg::SP_W-1:0] wr_val
);
  timeunit 1ns;
  timeprecision 100ps;
  import aosc_pkg::*;

  /*******************************************/
  // Word writer
  /*******************************************/
  initial begin
    {sp_wr, fb_wr, align_wr, align_clr} = 4'h0;
    wr_ch = 1'h0;
    wr_val = 16'sh0000;
  end

  // Kind: 0 setpoint, 1 fallback, 2 alignment, 3 clear aligned flag
  task automatic send(input int kind, input int ch, input int val);
    int v;
    v = val;
    if (kind < 2 && v > 10000) v = 10000;
    if (kind < 2 && v < -10000) v = -10000;
    if (kind < 2 && cfg_range[ch] != RNG_V10 && v < 0) v = 0;
    @(negedge clk_sys);
    wr_ch = ch[CH_W-1:0];
    wr_val = v[SP_W-1:0];
    {sp_wr, fb_wr, align_wr, align_clr} = 4'h8 >> kind;
    @(negedge clk_sys);
    {sp_wr, fb_wr, align_wr, align_clr} = 4'h0;
    // Released data shows its inverse, never a stale copy
    wr_val = ~wr_val;
  endtask
endmodule

`default_nettype wire

/* tb/aosc_top_bench.sv */
/*
 * Self-checking bench for the output setpoint controller.
 * Assumes shortened refresh, watchdog and link counts on the top.
 */
`default_nettype none

module aosc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import aosc_pkg::*;

  localparam int RF = 20;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  aosc_range_t cfg_range [NCH] = '{RNG_V10, RNG_V10};
  aosc_lim_t cfg_lim_mode [NCH] = '{LIM_BOTH, LIM_BOTH};
  logic [NCH-1:0] cfg_lim_en = 2'h3, cfg_maintain = 2'h0;
  logic [NCH-1:0] cfg_wire_chk = 2'h0, short_pin = 2'h0, open_pin = 2'h0;
  logic task_run = 1'h1, prog_ok = 1'h1, pwr_ok_pin = 1'h1;
  logic hot_swap = 1'h0, prog_reload = 1'h0, int_err_in = 1'h0;
  logic cal_wr = 1'h0;
  logic [CH_W-1:0] cal_ch = 1'h0;
  logic signed [CODE_W-1:0] cal_gain = 16'sh0000, cal_ofs = 16'sh0000;
  logic sp_wr, fb_wr, align_wr, align_clr, dac_load, stat_pwr_err;
  logic stat_cfg_err, stat_int_err, stat_comm_err;
  logic [CH_W-1:0] wr_ch;
  logic signed [SP_W-1:0] wr_val;
  logic signed [SP_W-1:0] align_rd [NCH];
  logic [CODE_W-1:0] dac_code [NCH];
  logic [NCH-1:0] stat_ovf, stat_unf, stat_short, stat_open, aligned;
  int fail_count = 0;
  int checks_done = 0;
  time t0;

  aosc_top #(.REFRESH_CYCLES(RF), .WDOG_CYCLES(40), .COMM_CYCLES(100))
    i_aosc_top (
    .clk_sys, .rst, .cfg_range, .cfg_lim_en, .cfg_lim_mode, .cfg_maintain,
    .cfg_wire_chk, .sp_wr, .sp_ch(wr_ch), .sp_val(wr_val), .fb_wr,
    .fb_ch(wr_ch), .fb_val(wr_val), .align_wr, .align_clr,
    .align_ch(wr_ch), .align_val(wr_val), .cal_wr, .cal_ch, .cal_gain,
    .cal_ofs, .task_run, .prog_ok,
    .hot_swap, .prog_reload, .int_err_in, .pwr_ok_pin, .short_pin,
    .open_pin, .dac_code, .dac_load, .stat_ovf, .stat_unf, .stat_short,
    .stat_open, .stat_pwr_err, .stat_cfg_err, .stat_int_err,
    .stat_comm_err, .aligned, .align_rd);

  aosc_cpu_model i_aosc_cpu_model (.clk_sys, .cfg_range, .sp_wr, .fb_wr,
    .align_wr, .align_clr, .wr_ch, .wr_val);

  /*******************************************/
  // Helpers
  /*******************************************/
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t code %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmpb(input logic [2:0] g, input logic [2:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t flags %b expected %b", $time, g, e);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait for n load pulses, returns at a settled falling edge
  task automatic ticks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge clk_sys);
        k++;
      end while (dac_load !== 1'b1 && k < 3 * RF);
      if (dac_load !== 1'b1) begin
        fail_count++;
        $display("mismatch %0t load pulse missing", $time);
      end
    end
  endtask

  function automatic logic [15:0] ecode(aosc_range_t r, int v);
    int lo, hi, c;
    lo = r == RNG_V10 ? V_OUT_LO : r == RNG_I020 ? I0_OUT_LO : I4_OUT_LO;
    hi = r == RNG_V10 ? V_OUT_HI : r == RNG_I020 ? I0_OUT_HI : I4_OUT_HI;
    v = v > hi ? hi : v < lo ? lo : v;
    c = v * (r == RNG_V10 ? V_GAIN : r == RNG_I020 ? I0_GAIN : I4_GAIN);
    c = (c >>> GAIN_SH) + (r == RNG_I420 ? I4_OFS : 0);
    lo = r == RNG_V10 ? -32768 : 0;
    c = c > 32767 ? 32767 : c < lo ? lo : c;
    return c[15:0];
  endfunction

  function automatic logic [1:0] eflag(aosc_range_t r, aosc_lim_t m,
      logic en, int v);
    int lo, hi;
    hi = r == RNG_V10 ? V_NOM_HI : r == RNG_I020 ? I0_NOM_HI : I4_NOM_HI;
    lo = r == RNG_V10 ? V_NOM_LO : r == RNG_I020 ? I0_NOM_LO : I4_NOM_LO;
    return {en && v > hi && m != LIM_LOWER, en && v < lo && m != LIM_UPPER};
  endfunction

  // Channel 1 gets the opposite alignment to show independence
  task automatic step(aosc_range_t r, aosc_lim_t m, logic en, int sp,
      int al);
    int a, v;
    cfg_range = '{r, r};
    cfg_lim_mode = '{m, m};
    cfg_lim_en = {en, en};
    i_aosc_cpu_model.send(0, 0, sp);
    i_aosc_cpu_model.send(0, 1, sp);
    i_aosc_cpu_model.send(2, 0, al);
    i_aosc_cpu_model.send(2, 1, -al);
    ticks(2);
    for (int c = 0; c < 2; c++) begin
      a = c ? -al : al;
      a = a > 1500 ? 1500 : a < -1500 ? -1500 : a;
      v = sp + a;
      cmp(dac_code[c], ecode(r, v));
      cmpb({1'b0, stat_ovf[c], stat_unf[c]}, {1'b0, eflag(r, m, en, v)});
      cmp(align_rd[c], a[15:0]);
    end
  endtask

  /*******************************************/
  // Sequence
  /*******************************************/
  initial forever #2.5 clk_sys = ~clk_sys;

  initial begin
    #30000;
    fail_count++;
    summarize();
  end

  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'h0;
    cmp(dac_code[0], 16'h0000);
    ticks(2);
    t0 = $time;
    ticks(1);
    cmp(16'(($time - t0) / 5), 16'(RF));
    step(RNG_V10, LIM_BOTH, 1'h1, 10000, 1500);
    step(RNG_V10, LIM_BOTH, 1'h1, -10000, 1600);
    step(RNG_V10, LIM_UPPER, 1'h1, 10000, 1000);
    step(RNG_V10, LIM_LOWER, 1'h1, 10000, 1500);
    step(RNG_I020, LIM_BOTH, 1'h1, 0, -1500);
    step(RNG_I020, LIM_UPPER, 1'h1, 10000, 1500);
    step(RNG_I420, LIM_LOWER, 1'h1, 0, -1500);
    step(RNG_I420, LIM_BOTH, 1'h0, 10000, 1500);
    cmpb({1'b0, aligned}, 3'h3);
    i_aosc_cpu_model.send(3, 0, 0);
    ticks(1);
    cmpb({1'b0, aligned}, 3'h2);
    // Fault hold on a shorted voltage channel
    step(RNG_V10, LIM_BOTH, 1'h1, 2000, 0);
    short_pin = 2'h1;
    repeat (6) @(negedge clk_sys);
    i_aosc_cpu_model.send(0, 0, 4000);
    i_aosc_cpu_model.send(0, 1, 4000);
    ticks(2);
    cmp(dac_code[0], ecode(RNG_V10, 2000));
    cmp(dac_code[1], ecode(RNG_V10, 4000));
    cmpb({1'b0, stat_short}, 3'h1);
    short_pin = 2'h0;
    // Open circuit counts only with the wiring check on
    step(RNG_I020, LIM_BOTH, 1'h1, 3000, 0);
    cfg_wire_chk = 2'h2;
    open_pin = 2'h3;
    repeat (6) @(negedge clk_sys);
    i_aosc_cpu_model.send(0, 0, 5000);
    i_aosc_cpu_model.send(0, 1, 5000);
    ticks(2);
    cmp(dac_code[0], ecode(RNG_I020, 5000));
    cmp(dac_code[1], ecode(RNG_I020, 3000));
    cmpb({1'b0, stat_open}, 3'h2);
    open_pin = 2'h0;
    cfg_wire_chk = 2'h0;
    // Stop: channel 0 falls back, channel 1 maintains
    step(RNG_V10, LIM_BOTH, 1'h1, 5000, 0);
    cfg_maintain = 2'h2;
    i_aosc_cpu_model.send(1, 0, -3000);
    task_run = 1'h0;
    ticks(2);
    cmp(dac_code[0], ecode(RNG_V10, -3000));
    cmp(dac_code[1], ecode(RNG_V10, 5000));
    task_run = 1'h1;
    prog_ok = 1'h0;
    i_aosc_cpu_model.send(1, 0, 2500);
    ticks(2);
    cmp(dac_code[0], ecode(RNG_V10, 2500));
    prog_ok = 1'h1;
    repeat (130) @(negedge clk_sys);
    ticks(1);
    cmpb({2'h0, stat_comm_err}, 3'h1);
    cmp(dac_code[0], ecode(RNG_V10, 2500));
    // Trim on channel 0 only; a fresh setpoint also ends the link loss
    @(negedge clk_sys);
    cal_wr = 1'h1;
    cal_gain = 16'sh0006;
    cal_ofs = 16'sh0064;
    @(negedge clk_sys);
    cal_wr = 1'h0;
    i_aosc_cpu_model.send(0, 0, 4096);
    i_aosc_cpu_model.send(0, 1, 4096);
    ticks(2);
    cmp(dac_code[0], 16'(V_GAIN + 16'sh006a));
    cmp(dac_code[1], ecode(RNG_V10, 4096));
    // Causes that force every channel to zero
    for (int k = 0; k < 5; k++) begin
      pwr_ok_pin = k != 0;
      cfg_range[1] = k == 1 ? aosc_range_t'(2'h3) : RNG_V10;
      int_err_in = k == 2;
      hot_swap = k == 3;
      prog_reload = k == 4;
      ticks(2);
      cmp(dac_code[0], 16'h0000);
      cmp(dac_code[1], 16'h0000);
      cmpb({stat_pwr_err, stat_cfg_err, stat_int_err},
        k < 3 ? 3'h4 >> k : 3'h0);
    end
    summarize();
  end
endmodule

`default_nettype wire
